// ### design/nvh_user_port.sv
`default_nettype none
module nvh_user_port #(
  parameter int channel_count_param = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Command channels
  input wire logic main_cmd_request,
  input wire logic [2:0] sub_cmd_request,
  input wire nvh_pkg::nvh_cmd_s [3:0] chan_cmd,
  input wire logic [15:0][31:0] custom_submit_words,
  input wire logic [31:0] completion_timeout_cycles,
  output logic [3:0] chan_busy,
  // Status
  output var nvh_pkg::nvh_drive_s drive_info,
  output logic [3:0] chan_error_flag,
  output logic [31:0] main_error_vector,
  output logic [2:0][31:0] sub_error_vector,
  output logic [15:0] admin_completion_status,
  output logic [3:0][15:0] io_completion_status,
  output logic [31:0] capability_snapshot,
  output logic [31:0] core_version_word,
  output logic [3:0][31:0] custom_completion_words,
  // User FIFOs
  input wire logic [3:0][15:0] rx_fifo_fill_count,
  output logic [3:0] rx_fifo_write_strobe,
  output logic [3:0][255:0] rx_fifo_write_word,
  input wire logic [3:0][15:0] tx_fifo_level_count,
  output logic [3:0] tx_fifo_read_strobe,
  input wire logic [3:0][255:0] tx_fifo_read_word,
  // Identify and custom RAM
  output logic ident_write_strobe,
  output logic [7:0] ident_dword_mask,
  output logic [7:0] ident_word_index,
  output logic [255:0] ident_write_word,
  output logic custom_ram_write_strobe,
  output logic [7:0] custom_ram_dword_mask,
  output logic [7:0] custom_ram_index,
  output logic [255:0] custom_ram_write_word,
  // Engine side
  input wire logic init_done,
  input wire logic [31:0] eng_init_errors,
  input wire logic [31:0] eng_capability,
  input wire nvh_pkg::nvh_drive_s eng_drive_info,
  output logic [3:0] eng_issue,
  output var nvh_pkg::nvh_cmd_s [3:0] eng_cmd,
  output logic [15:0][31:0] eng_submit_words,
  input wire logic [3:0] eng_cpl_valid,
  input wire logic [3:0][15:0] eng_cpl_status,
  input wire logic [3:0][31:0] eng_cpl_words,
  input wire logic [3:0] eng_rd_valid,
  input wire logic [3:0][255:0] eng_rd_word,
  output logic [3:0] eng_rd_ready,
  output logic [3:0] eng_tx_valid,
  output logic [3:0][255:0] eng_tx_word,
  input wire logic eng_ram_valid,
  input wire logic [7:0] eng_ram_mask,
  input wire logic [255:0] eng_ram_word
);
  logic rst_meta_n;
  logic rst_sync_n;
  logic [1:0] init_lag;
  logic [3:0] req_all;
  logic [3:0][31:0] err_q;
  nvh_pkg::nvh_cmd_s [3:0] cmd_q;
  nvh_pkg::nvh_state_e [3:0] st_q;
  logic [7:0] ram_idx;
  logic ram_hit;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      init_lag <= '0;
    end else begin
      init_lag <= {init_lag[0], init_done};
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      core_version_word <= '0;
    end else begin
      core_version_word <= nvh_pkg::CORE_VERSION;
    end
  end

  assign req_all = {sub_cmd_request, main_cmd_request};
  assign main_error_vector = err_q[0];
  assign sub_error_vector = err_q[3:1];

  for (genvar g = 0; g < nvh_pkg::CHAN_MAX; g++) begin : g_chan
    localparam bit ACTIVE = g < channel_count_param;
    nvh_pkg::nvh_state_e state;
    nvh_pkg::nvh_state_e next_state;
    logic [3:0] word_cnt;
    logic [47:0] remain;
    logic [31:0] tmo_cnt;
    logic [31:0] next_err;
    logic tx_pend;
    logic legal;
    logic accept;
    logic admin;
    logic timed_out;
    logic cpl_hit;
    logic init_ok;

    assign legal = ACTIVE && ((g == 0) ? (chan_cmd[g].code inside {nvh_pkg::CMD_IDENTIFY,
      nvh_pkg::CMD_SHUTDOWN, nvh_pkg::CMD_WRITE, nvh_pkg::CMD_READ, nvh_pkg::CMD_SMART,
      nvh_pkg::CMD_FLUSH}) : (chan_cmd[g].code inside {nvh_pkg::CMD_WRITE, nvh_pkg::CMD_READ}));
    assign accept = state == nvh_pkg::CS_IDLE && req_all[g] && legal;
    assign admin = g == 0 && (cmd_q[g].code inside {nvh_pkg::CMD_IDENTIFY,
      nvh_pkg::CMD_SHUTDOWN, nvh_pkg::CMD_SMART});
    assign timed_out = state == nvh_pkg::CS_WAIT_CPL && completion_timeout_cycles != '0
      && tmo_cnt == completion_timeout_cycles;
    assign cpl_hit = state == nvh_pkg::CS_WAIT_CPL && eng_cpl_valid[g];
    assign init_ok = !ACTIVE || ((g == 0) ? init_done : init_lag[nvh_pkg::SUB_BUSY_LAG - 1]);
    assign st_q[g] = state;

    always_comb begin
      next_state = state;
      unique case (state)
        nvh_pkg::CS_INIT: if (init_ok) next_state = nvh_pkg::CS_IDLE;
        nvh_pkg::CS_IDLE: begin
          if (accept) begin
            next_state = (chan_cmd[g].code == nvh_pkg::CMD_WRITE) ? nvh_pkg::CS_TX_WAIT
              : nvh_pkg::CS_WAIT_CPL;
          end
        end
        // burst only when sixteen words wait
        nvh_pkg::CS_TX_WAIT: begin
          if (tx_fifo_level_count[g][15:4] != '0) next_state = nvh_pkg::CS_TX_BURST;
        end
        nvh_pkg::CS_TX_BURST: begin
          if (word_cnt == nvh_pkg::BURST_LAST) begin
            next_state = (remain == 48'h1) ? nvh_pkg::CS_WAIT_CPL : nvh_pkg::CS_TX_WAIT;
          end
        end
        nvh_pkg::CS_WAIT_CPL: if (cpl_hit || timed_out) next_state = nvh_pkg::CS_IDLE;
        default: next_state = nvh_pkg::CS_IDLE;
      endcase
    end

    // busy held while a command runs
    always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        state <= nvh_pkg::CS_INIT;
        chan_busy[g] <= nvh_pkg::BUSY_RST;
      end else begin
        state <= next_state;
        chan_busy[g] <= ACTIVE && next_state != nvh_pkg::CS_IDLE;
      end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        cmd_q[g] <= '0;
        remain <= '0;
        word_cnt <= '0;
        tmo_cnt <= '0;
      end else begin
        if (accept) begin
          cmd_q[g] <= chan_cmd[g];
          remain <= chan_cmd[g].xfer_len;
        end else if (state == nvh_pkg::CS_TX_BURST && word_cnt == nvh_pkg::BURST_LAST) begin
          remain <= remain - 48'h1;
        end
        word_cnt <= (state == nvh_pkg::CS_TX_BURST) ? word_cnt + 4'h1 : 4'h0;
        tmo_cnt <= (state == nvh_pkg::CS_WAIT_CPL) ? tmo_cnt + 32'h1 : 32'h0;
      end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        eng_issue[g] <= 1'b0;
        eng_cmd[g] <= '0;
      end else begin
        eng_issue[g] <= accept;
        if (accept) eng_cmd[g] <= chan_cmd[g];
      end
    end

    // sixteen strobes per burst, data a clock later
    always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        tx_fifo_read_strobe[g] <= 1'b0;
        tx_pend <= 1'b0;
        eng_tx_valid[g] <= 1'b0;
        eng_tx_word[g] <= '0;
      end else begin
        tx_fifo_read_strobe[g] <= next_state == nvh_pkg::CS_TX_BURST;
        tx_pend <= tx_fifo_read_strobe[g];
        eng_tx_valid[g] <= tx_pend;
        if (tx_pend) eng_tx_word[g] <= tx_fifo_read_word[g];
      end
    end

    // space from inverted write counter, padded ones read as full
    always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        eng_rd_ready[g] <= 1'b0;
        rx_fifo_write_strobe[g] <= 1'b0;
        rx_fifo_write_word[g] <= '0;
      end else begin
        eng_rd_ready[g] <= state == nvh_pkg::CS_WAIT_CPL && cmd_q[g].code == nvh_pkg::CMD_READ
          && (~rx_fifo_fill_count[g]) > nvh_pkg::RX_MARGIN;
        rx_fifo_write_strobe[g] <= eng_rd_valid[g] && eng_rd_ready[g];
        if (eng_rd_valid[g] && eng_rd_ready[g]) rx_fifo_write_word[g] <= eng_rd_word[g];
      end
    end

    always_comb begin
      next_err = err_q[g];
      if (timed_out) next_err[admin ? nvh_pkg::ERR_ADM_TMO : nvh_pkg::ERR_IO_TMO] = 1'b1;
      if (cpl_hit && eng_cpl_status[g] != '0) begin
        next_err[admin ? nvh_pkg::ERR_ADM_STAT : nvh_pkg::ERR_IO_STAT] = 1'b1;
      end
      if (g == 0) next_err = next_err | (eng_init_errors & nvh_pkg::INIT_ERR_MASK);
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        err_q[g] <= '0;
        chan_error_flag[g] <= 1'b0;
        io_completion_status[g] <= '0;
      end else begin
        err_q[g] <= next_err;
        chan_error_flag[g] <= |next_err;
        if (cpl_hit && !admin) io_completion_status[g] <= eng_cpl_status[g];
      end
    end

    if (g == 0) begin : g_main
      always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          admin_completion_status <= '0;
          drive_info <= '0;
          custom_completion_words <= '0;
          capability_snapshot <= '0;
          eng_submit_words <= '0;
        end else begin
          if (cpl_hit && admin) admin_completion_status <= eng_cpl_status[0];
          if (cpl_hit && eng_cpl_status[0] == '0 && cmd_q[0].code == nvh_pkg::CMD_IDENTIFY) begin
            drive_info <= eng_drive_info;
          end
          // completion words of smart and flush
          if (cpl_hit && cmd_q[0].code inside {nvh_pkg::CMD_SMART, nvh_pkg::CMD_FLUSH}) begin
            custom_completion_words <= eng_cpl_words;
          end
          if (eng_init_errors[nvh_pkg::ERR_CAP]) capability_snapshot <= eng_capability;
          if (accept) eng_submit_words <= custom_submit_words;
        end
      end
    end
  end

  // Data words for identify and smart share one index counter
  assign ram_hit = eng_ram_valid && st_q[0] == nvh_pkg::CS_WAIT_CPL;

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ram_idx <= '0;
      ident_write_strobe <= 1'b0;
      ident_dword_mask <= '0;
      ident_word_index <= '0;
      ident_write_word <= '0;
      custom_ram_write_strobe <= 1'b0;
      custom_ram_dword_mask <= '0;
      custom_ram_index <= '0;
      custom_ram_write_word <= '0;
    end else begin
      ram_idx <= (st_q[0] == nvh_pkg::CS_IDLE) ? 8'h00 : ram_idx + {7'h00, ram_hit};
      ident_write_strobe <= ram_hit && cmd_q[0].code == nvh_pkg::CMD_IDENTIFY;
      custom_ram_write_strobe <= ram_hit && cmd_q[0].code == nvh_pkg::CMD_SMART;
      if (ram_hit) begin
        ident_dword_mask <= eng_ram_mask;
        ident_word_index <= ram_idx;
        ident_write_word <= eng_ram_word;
        custom_ram_dword_mask <= eng_ram_mask;
        custom_ram_index <= ram_idx;
        custom_ram_write_word <= eng_ram_word;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_sync_n);

  busy_on_accept_a: assert property (g_chan[0].accept |=> chan_busy[0])
    else $error("busy did not rise on accepted request");
  reserved_ignored_a: assert property ((st_q[1] == nvh_pkg::CS_IDLE && req_all[1]
    && !g_chan[1].legal) |=> !chan_busy[1])
    else $error("reserved code raised busy");
  burst_start_a: assert property ($rose(tx_fifo_read_strobe[0]) |->
    $past(tx_fifo_level_count[0][15:4]) != '0 ##15 tx_fifo_read_strobe[0])
    else $error("burst started without data or ended early");
  burst_end_a: assert property ($rose(tx_fifo_read_strobe[0]) |->
    ##16 !tx_fifo_read_strobe[0]) else $error("burst longer than sixteen words");
  sub_busy_lag_a: assert property (($fell(chan_busy[0]) && channel_count_param > 1
    && $past(st_q[0]) == nvh_pkg::CS_INIT) |-> ##2 $fell(chan_busy[1]))
    else $error("secondary busy lag wrong");
  flag_sticky_a: assert property (chan_error_flag[2] |=> chan_error_flag[2]
    && sub_error_vector[1] != '0)
    else $error("error flag not sticky");
  sub_err_bits_a: assert property (((sub_error_vector[1] | sub_error_vector[2])
    & ~nvh_pkg::SUB_ERR_MASK) == '0) else $error("reserved secondary error bit set");
  tmo_disabled_a: assert property ($rose(sub_error_vector[2][nvh_pkg::ERR_IO_TMO])
    |-> $past(completion_timeout_cycles) != '0)
    else $error("timeout flagged while disabled");
  ident_index_a: assert property ((ident_write_strobe && $past(ident_write_strobe))
    |-> ident_word_index == $past(ident_word_index) + 8'h01)
    else $error("identify index did not advance");
  rx_space_a: assert property (rx_fifo_write_strobe[1] |->
    (~$past(rx_fifo_fill_count[1], 2)) > nvh_pkg::RX_MARGIN)
    else $error("receive write without space");
endmodule
`default_nettype wire

// ### design/nvh_pkg.sv
// Behaviour
// - Main codes: identify, shutdown, write, read, smart, flush
// - Secondary channels take only write and read
// - Busy rises on start, blocks new requests
// - Sixteen submission words sent verbatim for smart/flush
// - Capacity and block flag latched by identify
// - Error flag follows nonzero vector, sticky
// - Main error bits for init, timeouts, status
// - Bit 1 flags unacceptable capability register
// - Upper main bits mirror uncorrectable error status
// - Secondary vectors use only bits 4, 5
// - Completion timeout in cycles, zero disables
// - Completion status: phase flag plus status field
// - Capability fields exposed on capability error
// - Read data to receive FIFO, checks space
// - Identify words indexed, controller then namespace
// - Smart words to custom RAM, completion words
// - Write bursts of sixteen words when available
// - Channel count parameter, absent channels inactive
// - Secondary busy falls two cycles after main
`default_nettype none
package nvh_pkg;
  localparam int CHAN_MAX = 4;
  localparam logic [2:0] CMD_IDENTIFY = 3'h0;
  localparam logic [2:0] CMD_SHUTDOWN = 3'h1;
  localparam logic [2:0] CMD_WRITE = 3'h2;
  localparam logic [2:0] CMD_READ = 3'h3;
  localparam logic [2:0] CMD_SMART = 3'h4;
  localparam logic [2:0] CMD_FLUSH = 3'h6;
  localparam logic [3:0] BURST_LAST = 4'hf;
  localparam logic [15:0] RX_MARGIN = 16'h0004;
  localparam logic [31:0] INIT_ERR_MASK = 32'h7f00ffc3;
  localparam logic [31:0] SUB_ERR_MASK = 32'h00000030;
  localparam int ERR_CAP = 1;
  localparam int ERR_ADM_TMO = 2;
  localparam int ERR_ADM_STAT = 3;
  localparam int ERR_IO_TMO = 4;
  localparam int ERR_IO_STAT = 5;
  localparam int SUB_BUSY_LAG = 2;
  localparam logic BUSY_RST = 1'b1;
  // Arbitrary value
  localparam logic [31:0] CORE_VERSION = 32'h00010000;
  typedef enum logic [2:0] {CS_INIT, CS_IDLE, CS_TX_WAIT, CS_TX_BURST, CS_WAIT_CPL} nvh_state_e;
  typedef struct packed {
    logic [2:0] code;
    logic [47:0] start_lba;
    logic [47:0] xfer_len;
  } nvh_cmd_s;
  typedef struct packed {
    logic [47:0] drive_capacity;
    logic block_size_flag;
  } nvh_drive_s;
endpackage
`default_nettype wire

// ### verification/nvh_fifo_model.sv
`default_nettype none
module nvh_fifo_model (
  // Clock
  input wire logic clock,
  // Bench control
  input wire logic [3:0] tx_ready,
  input wire logic [3:0] rx_full,
  // Transmit FIFO read side
  input wire logic [3:0] tx_fifo_read_strobe,
  output logic [3:0][15:0] tx_fifo_level_count,
  output logic [3:0][255:0] tx_fifo_read_word,
  // Receive FIFO write side
  output logic [3:0][15:0] rx_fifo_fill_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0][23:0] n_read;
  initial begin
    n_read = '0;
    tx_fifo_read_word = '0;
  end
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      rx_fifo_fill_count[c] = rx_full[c] ? 16'hfffe : 16'hfc00;
      tx_fifo_level_count[c] = tx_ready[c] ? 16'h0010 : 16'h000f;
    end
  end
  always @(posedge clock) begin
    for (int c = 0; c < 4; c++) begin
      if (tx_fifo_read_strobe[c]) begin
        tx_fifo_read_word[c] <= {8{c[7:0], n_read[c]}};
        n_read[c] <= n_read[c] + 24'h000001;
      end else begin
        // Off-strobe data is scrambled so a late capture cannot pass
        tx_fifo_read_word[c] <= ~tx_fifo_read_word[c];
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/nvh_user_port_tb_top.sv
`default_nettype none
module nvh_user_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic main_req = 1'b0;
  logic [2:0] sub_req = '0;
  nvh_pkg::nvh_cmd_s [3:0] cmd = '0;
  logic [15:0][31:0] subm = '0;
  logic [31:0] tmo = '0;
  logic init_done = 1'b0;
  logic [31:0] ierr = '0;
  logic [31:0] cap = '0;
  nvh_pkg::nvh_drive_s edrv = '0;
  logic [3:0] cpl_v = '0;
  logic [3:0][15:0] cpl_st = '0;
  logic [3:0][31:0] cpl_w = '0;
  logic [3:0] rd_v = '0;
  logic [3:0][255:0] rd_w = '0;
  logic ram_v = 1'b0;
  logic [7:0] ram_m = '0;
  logic [255:0] ram_w = '0;
  logic [3:0] tx_ok = '0;
  logic [3:0] rx_full = 4'h2;
  logic [5:0][2:0] rsv = {3'h7, 3'h6, 3'h5, 3'h4, 3'h1, 3'h0};
  logic [3:0] chan_busy, chan_error_flag, rx_fifo_write_strobe, tx_fifo_read_strobe;
  logic [3:0] eng_issue, eng_rd_ready, eng_tx_valid;
  logic ident_write_strobe, custom_ram_write_strobe;
  logic [7:0] ident_dword_mask, ident_word_index, custom_ram_dword_mask, custom_ram_index;
  logic [15:0] admin_completion_status;
  logic [31:0] main_error_vector, capability_snapshot, core_version_word;
  logic [255:0] ident_write_word, custom_ram_write_word;
  logic [2:0][31:0] sub_error_vector;
  logic [3:0][15:0] io_completion_status, rx_fifo_fill_count, tx_fifo_level_count;
  logic [3:0][31:0] custom_completion_words;
  logic [3:0][255:0] rx_fifo_write_word, tx_fifo_read_word, eng_tx_word;
  logic [15:0][31:0] eng_submit_words;
  nvh_pkg::nvh_drive_s drive_info;
  nvh_pkg::nvh_cmd_s [3:0] eng_cmd;
  logic [271:0] q_id[$], q_cr[$], q_rx[$], q_tx[$];
  int num_errors = 0, n_checks = 0, n_strb = 0, run = 0, cyc = 0;
  wire logic [271:0] id_o = {ident_dword_mask, ident_word_index, ident_write_word};
  wire logic [271:0] cr_o = {custom_ram_dword_mask, custom_ram_index, custom_ram_write_word};

  nvh_user_port #(.channel_count_param(4)) i_nvh_user_port (
    .clock, .rst_n, .main_cmd_request(main_req), .sub_cmd_request(sub_req), .chan_cmd(cmd),
    .custom_submit_words(subm), .completion_timeout_cycles(tmo), .chan_busy, .drive_info,
    .chan_error_flag, .main_error_vector, .sub_error_vector, .admin_completion_status,
    .io_completion_status, .capability_snapshot, .core_version_word, .custom_completion_words,
    .rx_fifo_fill_count, .rx_fifo_write_strobe, .rx_fifo_write_word, .tx_fifo_level_count,
    .tx_fifo_read_strobe, .tx_fifo_read_word, .ident_write_strobe, .ident_dword_mask,
    .ident_word_index, .ident_write_word, .custom_ram_write_strobe, .custom_ram_dword_mask,
    .custom_ram_index, .custom_ram_write_word, .init_done, .eng_init_errors(ierr),
    .eng_capability(cap), .eng_drive_info(edrv), .eng_issue, .eng_cmd, .eng_submit_words,
    .eng_cpl_valid(cpl_v), .eng_cpl_status(cpl_st), .eng_cpl_words(cpl_w),
    .eng_rd_valid(rd_v), .eng_rd_word(rd_w), .eng_rd_ready, .eng_tx_valid, .eng_tx_word,
    .eng_ram_valid(ram_v), .eng_ram_mask(ram_m), .eng_ram_word(ram_w));
  nvh_fifo_model i_nvh_fifo_model (.clock, .tx_ready(tx_ok), .rx_full, .tx_fifo_read_strobe,
    .tx_fifo_level_count, .tx_fifo_read_word, .rx_fifo_fill_count);

  always #5 clock = ~clock;

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      num_errors++;
      give_verdict();
    end
  end

  task automatic chk(input logic [511:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask

  function automatic logic [255:0] xw(input int c, n);
    return {8{c[7:0], n[23:0]}};
  endfunction

  // Stream outputs are matched in order against queues filled by the stimulus
  always @(negedge clock) begin
    if (ident_write_strobe === 1'b1) chk(id_o, q_id.pop_front(), "id");
    if (custom_ram_write_strobe === 1'b1) chk(cr_o, q_cr.pop_front(), "cr");
    for (int c = 0; c < 4; c++) begin
      if (rx_fifo_write_strobe[c] === 1'b1)
        chk({8'(c), 8'h00, rx_fifo_write_word[c]}, q_rx.pop_front(), "rx");
      if (eng_tx_valid[c] === 1'b1)
        chk({8'(c), 8'h00, eng_tx_word[c]}, q_tx.pop_front(), "tx");
      if (tx_fifo_read_strobe[c] === 1'b1) begin
        n_strb++;
        run++;
      end
    end
    if (tx_fifo_read_strobe === 4'h0 && run != 0) begin
      chk(run, 16, "run");
      run = 0;
    end
  end

  task automatic tend(input string s);
    $display("test %s done", s);
  endtask

  task automatic wbusy(input int c, input logic v);
    for (int k = 0; k < 300; k++) begin
      @(negedge clock);
      if (chan_busy[c] === v) break;
    end
  endtask

  task automatic do_reset();
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (5) @(posedge clock);
    chk(chan_busy, 4'hf, "rbusy");
    chk({main_error_vector, sub_error_vector, chan_error_flag, drive_info}, '0, "rst");
    rst_n <= 1'b1;
  endtask

  task automatic issue(input int c, input logic [2:0] code, input logic [47:0] len);
    logic [47:0] lba;
    lba = {$urandom, 16'h0000};
    @(posedge clock);
    cmd[c] <= '{code, lba, len};
    for (int k = 0; k < 16; k++) subm[k] <= $urandom;
    if (c == 0) main_req <= 1'b1;
    else sub_req[c-1] <= 1'b1;
    wbusy(c, 1'b1);
    chk(eng_issue[c], 1'b1, "issue");
    chk(eng_cmd[c], {code, lba, len}, "cmd");
    if (code[2]) chk(eng_submit_words, subm, "subm");
    @(posedge clock);
    if (c == 0) main_req <= 1'b0;
    else sub_req[c-1] <= 1'b0;
  endtask

  task automatic done(input int c, input logic [15:0] st, input logic adm);
    @(posedge clock);
    cpl_v[c] <= 1'b1;
    cpl_st[c] <= st;
    cpl_w <= {$urandom, $urandom, $urandom, $urandom};
    @(posedge clock);
    cpl_v[c] <= 1'b0;
    wbusy(c, 1'b0);
    if (adm) chk(admin_completion_status, st, "adm");
    else chk(io_completion_status[c], st, "io");
    if (st != 0) chk(chan_error_flag[c], 1'b1, "eflag");
  endtask

  task automatic ram_push(input int i, ref logic [271:0] q[$]);
    logic [7:0] m;
    logic [255:0] w;
    m = 8'($urandom);
    w = {8{$urandom}};
    q.push_back({m, i[7:0], w});
    @(posedge clock);
    ram_v <= 1'b1;
    ram_m <= m;
    ram_w <= w;
  endtask

  task automatic rd_push(input int c, input logic [255:0] w);
    rd_v[c] <= 1'b1;
    rd_w[c] <= w;
    for (int k = 0; k < 50; k++) begin
      @(negedge clock);
      if (eng_rd_ready[c] === 1'b1) break;
    end
    q_rx.push_back({8'(c), 8'h00, w});
    @(posedge clock);
  endtask

  task automatic wr(input int c, input int len);
    issue(c, nvh_pkg::CMD_WRITE, 48'(len));
    n_strb = 0;
    for (int i = 0; i < 16 * len; i++) q_tx.push_back({8'(c), 8'h00, xw(c, i)});
    repeat (10) @(negedge clock);
    chk(n_strb, 0, "stall");
    @(posedge clock);
    tx_ok[c] <= 1'b1;
    repeat (40 * len) @(negedge clock);
    chk(n_strb, 16 * len, "strb");
    chk(q_tx.size(), 0, "txn");
    @(posedge clock);
    tx_ok[c] <= 1'b0;
  endtask

  initial begin
    void'($urandom(32'h0ac16295));
    do_reset();
    repeat (3) @(posedge clock);
    init_done <= 1'b1;
    // small lengths keep 512-byte block mode legal
    edrv <= {$urandom, 16'h0000, 1'b0};
    wbusy(0, 1'b0);
    chk(chan_busy, 4'he, "lag0");
    @(negedge clock);
    chk(chan_busy, 4'he, "lag1");
    @(negedge clock);
    chk(chan_busy, 4'h0, "lag2");
    chk(drive_info, '0, "drv0");
    chk(core_version_word, nvh_pkg::CORE_VERSION, "ver");
    tend("init");
    for (int i = 0; i < 6; i++) begin
      @(posedge clock);
      cmd[0].code <= i[0] ? 3'h7 : 3'h5;
      for (int c = 1; c < 4; c++) cmd[c].code <= rsv[(i + c) % 6];
      main_req <= 1'b1;
      sub_req <= 3'h7;
      repeat (4) @(negedge clock);
      chk({chan_busy, eng_issue}, '0, "rsv");
      @(posedge clock);
      main_req <= 1'b0;
      sub_req <= 3'h0;
    end
    tend("reserved");
    issue(0, nvh_pkg::CMD_IDENTIFY, '0);
    for (int i = 0; i < 130; i++) ram_push(i, q_id);
    @(posedge clock);
    ram_v <= 1'b0;
    done(0, 16'h0000, 1'b1);
    chk(drive_info, edrv, "drv");
    chk(q_id.size(), 0, "idn");
    tend("identify");
    issue(0, nvh_pkg::CMD_SMART, '0);
    for (int i = 0; i < 2; i++) ram_push(i, q_cr);
    @(posedge clock);
    ram_v <= 1'b0;
    done(0, 16'h0000, 1'b1);
    chk(custom_completion_words, cpl_w, "cpw");
    chk(q_cr.size(), 0, "crn");
    issue(0, nvh_pkg::CMD_FLUSH, '0);
    done(0, {15'($urandom), 1'b1}, 1'b0);
    chk(main_error_vector[5], 1'b1, "flerr");
    issue(0, nvh_pkg::CMD_SHUTDOWN, '0);
    done(0, {15'($urandom), 1'b1}, 1'b1);
    chk(main_error_vector[3], 1'b1, "aderr");
    issue(0, nvh_pkg::CMD_READ, 48'h1);
    done(0, 16'h0000, 1'b0);
    wr(0, 1);
    done(0, 16'h0000, 1'b0);
    tend("main");
    issue(1, nvh_pkg::CMD_READ, 48'h1);
    repeat (5) @(negedge clock);
    chk(eng_rd_ready[1], 1'b0, "full");
    @(posedge clock);
    rx_full[1] <= 1'b0;
    for (int i = 0; i < 16; i++) rd_push(1, {8{$urandom}});
    rd_v[1] <= 1'b0;
    done(1, 16'h0000, 1'b0);
    chk(q_rx.size(), 0, "rxn");
    wr(2, 2);
    done(2, 16'h0002, 1'b0);
    chk(sub_error_vector[1], 32'h00000020, "sberr");
    tend("data");
    @(posedge clock);
    tmo <= 32'd10;
    issue(3, nvh_pkg::CMD_READ, 48'h1);
    issue(0, nvh_pkg::CMD_SHUTDOWN, '0);
    wbusy(3, 1'b0);
    chk(sub_error_vector[2], 32'h00000010, "tmo");
    chk(chan_error_flag[3], 1'b1, "tflag");
    wbusy(0, 1'b0);
    chk(main_error_vector[2], 1'b1, "atmo");
    @(posedge clock);
    tmo <= '0;
    issue(3, nvh_pkg::CMD_READ, 48'h1);
    repeat (40) @(negedge clock);
    chk(chan_busy[3], 1'b1, "notmo");
    done(3, 16'h0000, 1'b0);
    tend("timeout");
    @(posedge clock);
    ierr <= $urandom | 32'h00000002;
    cap <= $urandom;
    repeat (3) @(negedge clock);
    chk(main_error_vector & ierr & nvh_pkg::INIT_ERR_MASK, ierr & nvh_pkg::INIT_ERR_MASK,
        "ierr");
    chk(main_error_vector[23:16], 8'h00, "rsvd");
    chk(capability_snapshot, cap, "cap");
    do_reset();
    tend("errors");
    give_verdict();
  end
endmodule
`default_nettype wire
